// file: rtl/sbsac_top.sv
// How it works
// RQ1 - All synchronous inputs are captured on the rising clock edge.
// RQ2 - Burst order select low gives linear order, high gives interleaved.
// RQ3 - An unconnected burst order select behaves as interleaved.
// RQ4 - A two-bit wraparound counter captures the burst start and makes later addresses.
// RQ5 - The counter loads from the two low address bits; only they step.
// RQ6 - Burst advance sampled at the edge decides whether the address steps.
// RQ7 - Processor strobe is ignored while the first chip select is high.
// RQ8 - Read starts when all selects are active and either strobe is low.
// RQ9 - A start latches the address into address register and counter, and the array.
// RQ10 - During a read with output enable low, data drives within the valid time.
// RQ11 - A processor strobe start ignores all write controls in that cycle.
// RQ12 - Write controls at the next edge after a processor start write the lanes.
// RQ13 - Host floats output enable and waits for high impedance before driving data.
// RQ14 - Any detected write, even partial, floats the data pins whatever output enable.
// RQ15 - Controller strobe write writes the data present in that same cycle.
// RQ16 - With both strobes low, only the processor strobe is acted on.
// RQ17 - Byte writes only happen on lanes selected while byte write enable is active.
// RQ18 - Active global write writes every lane regardless of byte controls.
// RQ19 - Writes finish with self-timed circuitry started at the clock edge.
// RQ20 - Three clocked chip selects; output enable is asynchronous, only gating drivers.
// RQ21 - Test serial output changes on the falling edge of the test clock.
// RQ22 - Test data and mode inputs are sampled on the rising test clock edge.
// RQ23 - Interleaved order visits start XOR 00, 01, 10, 11.
// RQ24 - Linear order adds one modulo four at each step.
// RQ25 - A write is global write low, or byte enable low with any lane select low.
// RQ26 - Outputs float while deselected and in the first clock leaving deselect (code: a read start drives them in that first clock if output enable is low).
// RQ27 - No strobe and no advance holds the counter, re-accessing the same location.
`default_nettype none
module sbsac_top
	import sbsac_pkg::*;
#(
	parameter int ADDR_BITS = sbsac_pkg::ADDR_W
) (
	input  wire logic                        mclk,
	input  wire logic                        rst,
	input  wire logic [ADDR_BITS-1:0]        addr,
	input  wire logic [sbsac_pkg::DATA_W-1:0] dq_in,
	output logic      [sbsac_pkg::DATA_W-1:0] dq_out,
	output logic                             dq_oe,
	input  wire logic                        chip_select_first_n,
	input  wire logic                        chip_select_second,
	input  wire logic                        chip_select_third_n,
	input  wire logic                        processor_addr_strobe_n,
	input  wire logic                        controller_addr_strobe_n,
	input  wire logic                        burst_advance_n,
	input  wire logic                        global_write_n,
	input  wire logic                        byte_write_enable_n,
	input  wire logic [sbsac_pkg::LANES-1:0]  byte_lane_select_n,
	input  wire logic                        output_enable_n,
	input  wire logic                        burst_order,
	input  wire logic                        burst_order_driven,
	input  wire logic                        tck,
	input  wire logic                        tdi,
	input  wire logic                        tms,
	output logic                             tdo
);
	import sbsac_pkg::*;

	typedef struct packed {
		sbsac_access_t                access;
		logic [ADDR_BITS-1:BURST_W]   base;
		logic [BURST_W-1:0]           start;
		logic [BURST_W-1:0]           step;
		logic                         order;
		logic                         tck_prev;
		logic                         scan_bit;
		logic                         tdo;
	} sbsac_state_t;

	sbsac_state_t st;
	sbsac_state_t next_st;

	sbsac_mem_if #(.AW(ADDR_BITS), .LW(LANE_W), .L(LANES)) mem_bus ();

	sbsac_mem #(
		.AW (ADDR_BITS),
		.LW (LANE_W),
		.L  (LANES)
	) u_mem (
		.mclk (mclk),
		.rst  (rst),
		.port (mem_bus.mem)
	);

	logic             selected;
	logic             p_go;
	logic             c_go;
	logic             wr_req;
	logic             order_eff;
	logic [LANES-1:0] lane_en;
	logic [LANES-1:0] next_we;

	assign selected  = !chip_select_first_n && chip_select_second && !chip_select_third_n; // RQ20
	assign p_go      = !processor_addr_strobe_n && !chip_select_first_n; // RQ7
	assign c_go      = !controller_addr_strobe_n && processor_addr_strobe_n; // RQ16
	assign wr_req    = !global_write_n || (!byte_write_enable_n && (byte_lane_select_n != LANES_ALL)); // RQ25
	// Strap has a pull-up, so a floating pin reads as interleaved
	assign order_eff = burst_order_driven ? burst_order : ORDER_INTERLEAVE; // RQ2 RQ3
	assign lane_en   = !global_write_n ? LANES_ALL : // RQ18
		(!byte_write_enable_n ? ~byte_lane_select_n : LANES_NONE); // RQ17

	always_comb begin
		next_st = st;
		next_we = LANES_NONE;
		next_st.order = order_eff;
		if (p_go) begin
			// Write controls are ignored on this edge; the write comes on the next one
			if (selected) begin
				next_st.access = SBSAC_READ; // RQ8 RQ11
				next_st.base   = addr[ADDR_BITS-1:BURST_W]; // RQ9
				next_st.start  = addr[BURST_W-1:0]; // RQ4 RQ5
				next_st.step   = STEP_ZERO;
			end else begin
				next_st.access = SBSAC_DESEL;
			end
		end else if (!controller_addr_strobe_n) begin
			if (selected && c_go) begin
				next_st.access = wr_req ? SBSAC_WRITE : SBSAC_READ; // RQ8 RQ15
				next_st.base   = addr[ADDR_BITS-1:BURST_W]; // RQ9
				next_st.start  = addr[BURST_W-1:0]; // RQ5
				next_st.step   = STEP_ZERO;
				next_we        = lane_en; // RQ15
			end else begin
				next_st.access = SBSAC_DESEL;
			end
		end else if (st.access != SBSAC_DESEL) begin
			if (!burst_advance_n) begin
				next_st.step = st.step + STEP_ONE; // RQ6 RQ4
			end
			next_st.access = wr_req ? SBSAC_WRITE : SBSAC_READ;
			next_we        = lane_en; // RQ12
		end
		// Test port: the test clock is a plain input watched for its edges
		next_st.tck_prev = tck;
		if (tck && !st.tck_prev) begin
			next_st.scan_bit = tms ? 1'b0 : tdi; // RQ22
		end
		if (!tck && st.tck_prev) begin
			next_st.tdo = st.scan_bit; // RQ21
		end
	end

	assign mem_bus.addr  = {next_st.base, sbsac_burst_lo(next_st.start, next_st.step, next_st.order)}; // RQ23 RQ24
	assign mem_bus.wdata = dq_in;
	assign mem_bus.we    = next_we;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			st <= '{access: SBSAC_DESEL, order: ORDER_INTERLEAVE, default: '0};
		end else begin
			st <= next_st; // RQ1
		end
	end

	assign dq_out = mem_bus.rdata;
	// Write controls seen with an access open float the pins at once, before the edge
	assign dq_oe  = !output_enable_n && (st.access == SBSAC_READ) && !wr_req; // RQ10 RQ14 RQ26 RQ20
	assign tdo    = st.tdo;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	sequence s_proc_start;
		p_go && selected;
	endsequence

	sequence s_read_open;
		st.access == SBSAC_READ && st.step == STEP_ZERO;
	endsequence

	a_proc_start_read: assert property (s_proc_start |=> s_read_open) // RQ11
		else $error("processor start did not open a read");
	a_start_latch: assert property (s_proc_start |=> st.start == $past(addr[BURST_W-1:0])) // RQ9
		else $error("burst start not latched from low address bits");
	// An ignored strobe leaves an open burst running, so only the address must stay untouched
	a_ce1_blocks: assert property (!processor_addr_strobe_n && chip_select_first_n |=>
		st.start == $past(st.start) && st.base == $past(st.base)) // RQ7
		else $error("processor strobe acted with first select high");
	a_write_floats: assert property (st.access == SBSAC_WRITE |-> !dq_oe) // RQ14
		else $error("data pins driven during write");
	a_desel_float: assert property (st.access == SBSAC_DESEL |-> !dq_oe) // RQ26
		else $error("data pins driven while deselected");
	a_ctrl_write: assert property (c_go && selected && !global_write_n |-> next_we == LANES_ALL
		##1 st.access == SBSAC_WRITE) // RQ15
		else $error("controller write not taken in same cycle");
	a_byte_lanes: assert property (global_write_n && next_we != LANES_NONE |->
		!byte_write_enable_n && next_we == ~byte_lane_select_n) // RQ17
		else $error("byte lane written without its select");
	a_hold_step: assert property (st.access != SBSAC_DESEL && processor_addr_strobe_n
		&& controller_addr_strobe_n && burst_advance_n |=> st.step == $past(st.step)) // RQ27
		else $error("burst counter moved without advance");
	a_wrap_four: assert property (s_proc_start ##1 (processor_addr_strobe_n && controller_addr_strobe_n
		&& !burst_advance_n) [*4] |=> st.step == STEP_ZERO) // RQ4
		else $error("burst counter does not wrap after four steps");
	a_read_drive: assert property (st.access == SBSAC_READ && !output_enable_n && !wr_req |-> dq_oe) // RQ10
		else $error("read data not driven with output enable low");
	a_tdo_fall: assert property (!tck && st.tck_prev |=> tdo == $past(st.scan_bit)) // RQ21
		else $error("test output did not follow falling test clock");
endmodule
`default_nettype wire

// file: rtl/sbsac_pkg.sv
`default_nettype none
package sbsac_pkg;
	localparam int ADDR_W  = 19;
	localparam int LANES   = 4;
	localparam int LANE_W  = 9;
	localparam int DATA_W  = LANES * LANE_W;
	localparam int BURST_W = 2;

	localparam logic       ORDER_LINEAR     = 1'b0;
	localparam logic       ORDER_INTERLEAVE = 1'b1;
	localparam logic [1:0] STEP_ZERO        = 2'h0;
	localparam logic [1:0] STEP_ONE         = 2'h1;
	localparam logic [3:0] LANES_ALL        = 4'hF;
	localparam logic [3:0] LANES_NONE       = 4'h0;

	typedef enum logic [1:0] {
		SBSAC_DESEL = 2'h0,
		SBSAC_READ  = 2'h1,
		SBSAC_WRITE = 2'h3
	} sbsac_access_t;

	function automatic logic [1:0] sbsac_burst_lo(input logic [1:0] start, input logic [1:0] step,
		input logic order);
		if (order == ORDER_INTERLEAVE) begin
			sbsac_burst_lo = start ^ step;
		end else begin
			sbsac_burst_lo = start + step;
		end
	endfunction
endpackage
`default_nettype wire

// file: rtl/sbsac_mem_if.sv
`default_nettype none
interface sbsac_mem_if #(
	parameter int AW = 19,
	parameter int LW = 9,
	parameter int L  = 4
);
	logic [AW-1:0]   addr;
	logic [L*LW-1:0] wdata;
	logic [L-1:0]    we;
	logic [L*LW-1:0] rdata;

	modport ctrl (output addr, output wdata, output we, input rdata);
	modport mem  (input addr, input wdata, input we, output rdata);
endinterface
`default_nettype wire

// file: rtl/sbsac_mem.sv
`default_nettype none
module sbsac_mem #(
	parameter int AW = 19,
	parameter int LW = 9,
	parameter int L  = 4
) (
	input  wire logic mclk,
	input  wire logic rst,
	sbsac_mem_if.mem  port
);
	logic [L*LW-1:0] rdata;
	logic [L*LW-1:0] next_rdata;

	genvar g;
	generate
		for (g = 0; g < L; g++) begin : g_lane
			logic [LW-1:0] cells [2**AW];
			always_ff @(posedge mclk) begin
				// Self-timed: the whole lane write completes at this one edge
				if (port.we[g]) begin
					cells[port.addr] <= port.wdata[g*LW +: LW]; // RQ19
				end
			end
			assign next_rdata[g*LW +: LW] = cells[port.addr];
		end
	endgenerate

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rdata <= '0;
		end else begin
			rdata <= next_rdata;
		end
	end

	assign port.rdata = rdata;
endmodule
`default_nettype wire

// file: verification/sbsac_host_bus.sv
`default_nettype none
module sbsac_host_bus
	import sbsac_pkg::*;
(
	input  wire logic                         mclk,
	input  wire logic [sbsac_pkg::DATA_W-1:0] dq_out,
	input  wire logic                         dq_oe,
	input  wire logic                         output_enable_n,
	input  wire logic [sbsac_pkg::DATA_W-1:0] host_data,
	input  wire logic                         host_drive,
	output logic      [sbsac_pkg::DATA_W-1:0] dq_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [DATA_W-1:0] last = '0;

	always_ff @(posedge mclk) begin
		last <= dq_in;
	end

	// A released wire keeps changing, so a stale value never passes for data
	always_comb begin
		if (dq_oe) begin
			dq_in = dq_out;
		end else if (host_drive && output_enable_n) begin
			dq_in = host_data;
		end else begin
			dq_in = ~last;
		end
	end
endmodule
`default_nettype wire

// file: verification/tb_sync_burst_sram_access_control.sv
`default_nettype none
module tb_sync_burst_sram_access_control;
	import sbsac_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	// c: {proc, ctrl, cs1, adv}, {gw, bwe, oe, 0}, lane selects, {0, 0, driven, order}
	typedef struct packed {
		logic [15:0]       c;
		logic [5:0]        a;
		logic [DATA_W-1:0] d;
		logic [1:0]        ck;
		logic              eo;
		logic [DATA_W-1:0] ex;
	} sbsac_row_t;
	logic              mclk, rst, c2, c3, tck, tdi, tms, dq_oe, tdo;
	logic [DATA_W-1:0] dq_in, dq_out;
	sbsac_row_t        cur;
	int                err_count, tests_run;
	sbsac_row_t        rows [31] = '{
		'{16'h96F3, 6'h00, 36'h111111111, 2'h2, 1'h0, 36'h0},
		'{16'h96F3, 6'h01, 36'h222222222, 2'h0, 1'h0, 36'h0},
		'{16'h96F3, 6'h02, 36'h333333333, 2'h0, 1'h0, 36'h0},
		'{16'h96F3, 6'h03, 36'h444444444, 2'h0, 1'h0, 36'h0},
		'{16'h5CF3, 6'h01, 36'h0, 2'h0, 1'h0, 36'h0},
		'{16'hCCF3, 6'h00, 36'h0, 2'h3, 1'h1, 36'h222222222},
		'{16'hCCF3, 6'h00, 36'h0, 2'h3, 1'h1, 36'h111111111},
		'{16'hCCF3, 6'h00, 36'h0, 2'h3, 1'h1, 36'h444444444},
		'{16'hDCF3, 6'h00, 36'h0, 2'h3, 1'h1, 36'h333333333},
		'{16'h5CF2, 6'h01, 36'h0, 2'h3, 1'h1, 36'h333333333},
		'{16'hCCF2, 6'h00, 36'h0, 2'h3, 1'h1, 36'h222222222},
		'{16'hCCF2, 6'h00, 36'h0, 2'h3, 1'h1, 36'h333333333},
		'{16'hCCF2, 6'h00, 36'h0, 2'h3, 1'h1, 36'h444444444},
		'{16'h5CF0, 6'h03, 36'h0, 2'h3, 1'h1, 36'h111111111},
		'{16'hCCF0, 6'h00, 36'h0, 2'h3, 1'h1, 36'h444444444},
		'{16'hCCF0, 6'h00, 36'h0, 2'h3, 1'h1, 36'h333333333},
		'{16'hDEF0, 6'h00, 36'h0, 2'h3, 1'h0, 36'h222222222},
		'{16'h14F3, 6'h02, 36'h0, 2'h3, 1'h0, 36'h222222222},
		'{16'hDCF3, 6'h00, 36'h0, 2'h3, 1'h1, 36'h333333333},
		'{16'h5EF3, 6'h05, 36'h0, 2'h3, 1'h0, 36'h333333333},
		'{16'hD6F3, 6'h05, 36'hFFFFFFFFF, 2'h2, 1'h0, 36'h0},
		'{16'h7CF3, 6'h00, 36'h0, 2'h0, 1'h0, 36'h0},
		'{16'hDCF3, 6'h00, 36'h0, 2'h3, 1'h1, 36'hFFFFFFFFF},
		'{16'h5CF3, 6'h05, 36'h0, 2'h3, 1'h1, 36'hFFFFFFFFF},
		'{16'hDCF3, 6'h00, 36'h0, 2'h3, 1'h1, 36'hFFFFFFFFF},
		'{16'h9AA3, 6'h05, 36'h0, 2'h2, 1'h0, 36'h0},
		'{16'h9AF3, 6'h05, 36'h0, 2'h0, 1'h0, 36'h0},
		'{16'hDCF3, 6'h00, 36'h0, 2'h3, 1'h1, 36'hFF803FE00},
		'{16'h96F3, 6'h06, 36'h123456789, 2'h2, 1'h0, 36'h0},
		'{16'h5CF3, 6'h06, 36'h0, 2'h0, 1'h0, 36'h0},
		'{16'hDCF3, 6'h00, 36'h0, 2'h3, 1'h1, 36'h123456789}
	};

	sbsac_top #(.ADDR_BITS(6)) i_dut (.mclk(mclk), .rst(rst), .addr(cur.a), .dq_in(dq_in), .dq_out(dq_out),
		.dq_oe(dq_oe), .chip_select_first_n(cur.c[13]), .chip_select_second(c2), .chip_select_third_n(c3),
		.processor_addr_strobe_n(cur.c[15]), .controller_addr_strobe_n(cur.c[14]),
		.burst_advance_n(cur.c[12]), .global_write_n(cur.c[11]), .byte_write_enable_n(cur.c[10]),
		.byte_lane_select_n(cur.c[7:4]), .output_enable_n(cur.c[9]), .burst_order(cur.c[0]),
		.burst_order_driven(cur.c[1]), .tck(tck), .tdi(tdi), .tms(tms), .tdo(tdo));
	sbsac_host_bus i_host (.mclk(mclk), .dq_out(dq_out), .dq_oe(dq_oe), .output_enable_n(cur.c[9]),
		.host_data(cur.d), .host_drive(!(cur.c[11] && cur.c[10])), .dq_in(dq_in));

	initial begin
		mclk = 1'h0;
		forever #5 mclk = ~mclk;
	end

	task automatic note(input logic ok);
		tests_run++;
		if (ok !== 1'h1) begin
			err_count++;
			$display("[ERR] %0t output differs from expected", $time);
		end
	endtask
	task automatic chk_data(input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
		note(got === exp);
	endtask
	task automatic chk_flag(input logic exp, input logic got);
		note(got === exp);
	endtask
	task automatic cyc(input sbsac_row_t r);
		@(posedge mclk);
		cur <= r;
		#1;
	endtask
	task automatic rst_chk();
		chk_flag(1'h0, dq_oe);
		chk_data('0, dq_out);
		chk_flag(1'h0, tdo);
	endtask
	task automatic give_verdict();
		$display("Comparisons %0d, mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	initial begin
		rst = 1'h1;
		{c2, c3, tck, tdi, tms} = 5'h10;
		cur = rows[30];
		err_count = 0;
		tests_run = 0;
		repeat (9) @(posedge mclk);
		#1;
		rst_chk();
		@(posedge mclk);
		rst <= 1'h0;
		$display("reset test done");
		foreach (rows[i]) begin
			cyc(rows[i]);
			if (rows[i].ck[1]) chk_flag(rows[i].eo, dq_oe);
			if (rows[i].ck[0]) chk_data(rows[i].ex, dq_out);
		end
		$display("table test done");
		for (int k = 0; k < 2; k++) begin
			@(posedge mclk);
			{c2, c3} <= k ? 2'h3 : 2'h0;
			cur <= rows[29];
			@(posedge mclk);
			{c2, c3} <= 2'h2;
			cur <= rows[30];
			#1;
			chk_flag(1'h0, dq_oe);
		end
		$display("select test done");
		// Data input drops together with the falling test clock to prove it was taken at the rise
		for (int k = 0; k < 2; k++) begin
			@(posedge mclk);
			{tck, tdi, tms} <= {2'h3, k[0]};
			repeat (3) @(posedge mclk);
			#1;
			chk_flag(k[0], tdo);
			{tck, tdi} <= 2'h0;
			repeat (3) @(posedge mclk);
			#1;
			chk_flag(!k[0], tdo);
		end
		$display("test path done");
		@(posedge mclk);
		rst <= 1'h1;
		repeat (2) @(posedge mclk);
		#1;
		rst_chk();
		@(posedge mclk);
		rst <= 1'h0;
		$display("second reset done");
		give_verdict();
	end

	initial begin
		#5000;
		err_count++;
		$display("[ERR] %0t watchdog expired", $time);
		give_verdict();
	end
endmodule
`default_nettype wire
